// ### src/card_cycle_timer.sv
// Cycle-timing generator for a 16-bit card socket: address setup,
// command strobe active time and address hold, all counted in bus clocks.
// Assumes the host bridge issues one request pulse per card cycle and
// that the card wait pin is asynchronous to the bus clock.
`timescale 1ns/1ps

module card_cycle_timer
  import card_timer_pkg::*;
(
  // Clock and reset.
  input wire logic clock_i,
  input wire logic nrst_i,
  // Register port.
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  // Cycle request from the bridge.
  input wire logic req_i,
  input wire cycle_req_t req_info_i,
  output logic busy_o,
  output logic done_o,
  // Card side.
  input wire logic card_wait_n_i,
  output logic addr_valid_o,
  output logic card_io_o,
  output logic strobe_rd_n_o,
  output logic strobe_wr_n_o
);

  // ---------------------------------------------------------------------
  // Count lookup.
  // ---------------------------------------------------------------------
  // Picks setup, active and hold lengths for one cycle. Every timing set
  // value uses the same table, since only one set is defined.
  function automatic counts_t lookup(input win_cfg_t c, input logic io,
                                     input logic wide);
    counts_t r;
    logic upper;
    upper = c.wait_state_field[1];
    r.setup = io ? SETUP_IO : (upper ? SETUP_MEM_HI : SETUP_MEM_LO);
    r.hold = io ? HOLD_IO : (upper ? HOLD_MEM_HI : HOLD_MEM_LO);
    r.active = ACT8_BASE;
    if (!wide) begin
      // I/O looks at the low wait bit only; memory at both.
      if (io ? c.wait_state_field[0] : (c.wait_state_field != 2'h0)) begin
        r.active = ACT8_WAIT;
      end else if (c.zero_wait) begin
        r.active = ACT8_ZWS;
      end else begin
        r.active = ACT8_BASE;
      end
    end else if (io) begin
      // Zero-wait has no meaning for wide I/O and is ignored.
      r.active = c.wait_state_field[0] ? ACT16_IO_1 : ACT16_IO_0;
    end else begin
      case (c.wait_state_field)
        2'h0: r.active = c.zero_wait ? ACT16_MEM_ZWS : ACT16_MEM_00;
        2'h1: r.active = ACT16_MEM_01;
        2'h2: r.active = ACT16_MEM_10;
        default: r.active = ACT16_MEM_11;
      endcase
    end
    return r;
  endfunction

  // ---------------------------------------------------------------------
  // State.
  // ---------------------------------------------------------------------
  typedef struct packed {
    win_cfg_t [NUM_WIN-1:0] win;
    phase_t phase;
    logic [4:0] cnt;
    logic [4:0] hold_len;
    logic [2:0] wait_sync;
    logic wait_lvl;
    logic io;
    logic write;
    logic [DATA_W-1:0] rdata;
    logic done;
  } state_t;

  state_t st;
  state_t next_st;
  counts_t req_counts;
  // The active count is latched at the request so a window rewrite in
  // the middle of a cycle cannot change that cycle's timing.
  logic [4:0] act_len;
  logic [4:0] next_act_len;

  always_comb begin
    req_counts = lookup(st.win[req_info_i.win], req_info_i.io, req_info_i.wide);
  end

  // ---------------------------------------------------------------------
  // Next-state logic.
  // ---------------------------------------------------------------------
  // Register access, wait filtering and the cycle sequencer in one pass.
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    next_st.rdata = '0;

    // Window settings written by software steer every later cycle, except a write to the window requested in the same cycle, which is dropped.
    if (reg_wr_i && reg_addr_i < OFS_STATUS) begin
      next_st.win[reg_addr_i[2:0]] = win_cfg_t'(reg_wdata_i[4:0]);
    end
    if (reg_rd_i) begin
      if (reg_addr_i < OFS_STATUS) begin
        next_st.rdata = {3'h0, st.win[reg_addr_i[2:0]]};
      end else if (reg_addr_i == OFS_STATUS) begin
        next_st.rdata[ST_BUSY] = (st.phase != PH_IDLE);
        next_st.rdata[ST_WAIT] = st.wait_lvl;
        next_st.rdata[ST_PHASE_LSB +: 2] = st.phase;
      end
    end

    // The pin level is trusted only once the last two stages agree.
    next_st.wait_sync = {st.wait_sync[1:0], ~card_wait_n_i};
    if (st.wait_sync[2] == st.wait_sync[1]) begin
      next_st.wait_lvl = st.wait_sync[2];
    end

    case (st.phase)
      PH_IDLE: begin
        // Requests while a cycle runs are ignored; busy_o tells the bridge.
        if (req_i) begin
          next_st.phase = PH_SETUP;
          next_st.io = req_info_i.io;
          next_st.write = req_info_i.write;
          next_st.cnt = req_counts.setup + SETUP_EXTRA - 5'h01;
          next_st.hold_len = req_counts.hold + HOLD_EXTRA - 5'h01;
          next_st.win[req_info_i.win] = st.win[req_info_i.win];
        end
      end
      PH_SETUP: begin
        if (st.cnt == 5'h00) begin
          next_st.phase = PH_ACTIVE;
          // Reload with the active length from the same window.
          next_st.cnt = act_len - 5'h01;
        end else begin
          next_st.cnt = st.cnt - 5'h01;
        end
      end
      PH_ACTIVE: begin
        if (st.cnt != 5'h00) begin
          next_st.cnt = st.cnt - 5'h01;
        end else if (!st.wait_lvl) begin
          next_st.phase = PH_HOLD;
          next_st.cnt = st.hold_len;
        end
      end
      PH_HOLD: begin
        if (st.cnt == 5'h00) begin
          next_st.phase = PH_IDLE;
          next_st.done = 1'b1;
        end else begin
          next_st.cnt = st.cnt - 5'h01;
        end
      end
      default: begin
        next_st.phase = PH_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------------
  // Active length held through setup.
  // ---------------------------------------------------------------------
  // Captured in the same edge that leaves idle.
  always_comb begin
    next_act_len = act_len;
    if (st.phase == PH_IDLE && req_i) begin
      next_act_len = req_counts.active;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      act_len <= 5'h00;
    end else begin
      act_len <= next_act_len;
    end
  end

  // ---------------------------------------------------------------------
  // State register.
  // ---------------------------------------------------------------------
  // Reset drops any partial cycle: strobes high, address released.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= '0;
      for (int i = 0; i < NUM_WIN; i++) begin
        st.win[i] <= win_cfg_t'(WIN_RESET[4:0]);
      end
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs, each from a flip-flop.
  // ---------------------------------------------------------------------
  logic out_busy;
  logic out_addr;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      out_busy <= 1'b0;
      out_addr <= 1'b0;
      card_io_o <= 1'b0;
      strobe_rd_n_o <= 1'b1;
      strobe_wr_n_o <= 1'b1;
    end else begin
      out_addr <= (next_st.phase != PH_IDLE);
      out_busy <= (next_st.phase != PH_IDLE);
      card_io_o <= next_st.io;
      strobe_rd_n_o <= !((next_st.phase == PH_ACTIVE) && !next_st.write);
      strobe_wr_n_o <= !((next_st.phase == PH_ACTIVE) && next_st.write);
    end
  end

  assign addr_valid_o = out_addr;
  assign busy_o = out_busy;
  assign done_o = st.done;
  assign reg_rdata_o = st.rdata;

endmodule

// ### src/card_timer_pkg.sv
// Package for the 16-bit card cycle timer: register map, field layout,
// timing counts in bus clocks and the carrier structs.
// Assumes one clock domain; every count is in cycles of that clock.
package card_timer_pkg;

  // ---------------------------------------------------------------------
  // Register map.
  // ---------------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int NUM_WIN = 8;
  localparam logic [3:0] OFS_WIN0 = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h8;

  // Window configuration byte layout.
  localparam int WS_LSB = 0;
  localparam int ZWS_BIT = 2;
  localparam int TS_LSB = 3;
  localparam logic [7:0] WIN_RESET = 8'h08;

  // Status byte layout.
  localparam int ST_BUSY = 0;
  localparam int ST_WAIT = 1;
  localparam int ST_PHASE_LSB = 2;

  // ---------------------------------------------------------------------
  // Timing counts in bus clocks.
  // ---------------------------------------------------------------------
  localparam logic [4:0] SETUP_IO = 5'h03;
  localparam logic [4:0] SETUP_MEM_LO = 5'h02;
  localparam logic [4:0] SETUP_MEM_HI = 5'h04;
  localparam logic [4:0] SETUP_EXTRA = 5'h02;
  localparam logic [4:0] HOLD_IO = 5'h02;
  localparam logic [4:0] HOLD_MEM_LO = 5'h02;
  localparam logic [4:0] HOLD_MEM_HI = 5'h03;
  localparam logic [4:0] HOLD_EXTRA = 5'h01;
  localparam logic [4:0] ACT8_BASE = 5'h13;
  localparam logic [4:0] ACT8_WAIT = 5'h17;
  localparam logic [4:0] ACT8_ZWS = 5'h07;
  localparam logic [4:0] ACT16_IO_0 = 5'h07;
  localparam logic [4:0] ACT16_IO_1 = 5'h0b;
  localparam logic [4:0] ACT16_MEM_00 = 5'h09;
  localparam logic [4:0] ACT16_MEM_01 = 5'h0d;
  localparam logic [4:0] ACT16_MEM_10 = 5'h11;
  localparam logic [4:0] ACT16_MEM_11 = 5'h17;
  localparam logic [4:0] ACT16_MEM_ZWS = 5'h05;

  // ---------------------------------------------------------------------
  // Carriers.
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {PH_IDLE, PH_SETUP, PH_ACTIVE, PH_HOLD} phase_t;

  typedef struct packed {
    logic [2:0] win;
    logic io;
    logic wide;
    logic write;
  } cycle_req_t;

  typedef struct packed {
    logic [1:0] timing_set_field;
    logic zero_wait;
    logic [1:0] wait_state_field;
  } win_cfg_t;

  typedef struct packed {
    logic [4:0] setup;
    logic [4:0] active;
    logic [4:0] hold;
  } counts_t;

endpackage

// ### testbench/card_timer_properties.sv
// Checker for the card cycle timer: strobe, address and done timing.
// Assumes it is bound to the timer and sees only the timer's ports.
`timescale 1ns/1ps
module card_timer_properties
  import card_timer_pkg::*;
(
  // Watched ports.
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic req_i,
  input wire logic reg_rd_i,
  input wire logic [DATA_W-1:0] reg_rdata_o,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic addr_valid_o,
  input wire logic strobe_rd_n_o,
  input wire logic strobe_wr_n_o
);
  // ---------------------------------------------------------------
  // Cycle shape.
  // ---------------------------------------------------------------
  // Either strobe low means the command is active.
  wire cmd = !strobe_rd_n_o || !strobe_wr_n_o;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  sequence open_s; !cmd [*4]; endsequence
  sequence hold_s; addr_valid_o [*3]; endsequence
  start_cycle_a: assert property (req_i && !busy_o |=> busy_o && addr_valid_o)
    else $error("request not taken");
  setup_gap_a: assert property ($rose(addr_valid_o) |-> open_s)
    else $error("strobe too early");
  setup_seen_a: assert property ($rose(cmd) |-> $past(addr_valid_o, 4))
    else $error("setup too short");
  active_min_a: assert property ($rose(cmd) |-> cmd [*5])
    else $error("strobe too short");
  hold_min_a: assert property ($fell(cmd) |-> hold_s)
    else $error("hold too short");
  strobe_addr_a: assert property (cmd |-> addr_valid_o && busy_o)
    else $error("strobe without address");
  one_strobe_a: assert property (!(!strobe_rd_n_o && !strobe_wr_n_o))
    else $error("both strobes low");
  done_pulse_a: assert property (done_o |-> $past(busy_o) && !busy_o ##1 !done_o)
    else $error("bad done pulse");
  rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == '0)
    else $error("read data not idle");
endmodule

bind card_cycle_timer card_timer_properties card_timer_properties_i (.clock_i, .nrst_i,
  .req_i, .reg_rd_i, .reg_rdata_o, .busy_o, .done_o, .addr_valid_o, .strobe_rd_n_o,
  .strobe_wr_n_o);

// ### testbench/card_model.sv
// Card model: answers the command strobe, optionally holding wait low.
// Assumes a pull-up on the wait pin, so a released pin reads high.
`timescale 1ns/1ps
module card_model (
  // Clock, reset and card pins.
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic strobe_rd_n_i,
  input wire logic strobe_wr_n_i,
  input wire logic [5:0] wait_len_i,
  output logic card_wait_n_o
);
  logic [5:0] cnt;
  // Counts clocks of active strobe; cleared between cycles.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt <= '0;
    end else if (!strobe_rd_n_i || !strobe_wr_n_i) begin
      cnt <= cnt + 6'h01;
    end else begin
      cnt <= '0;
    end
  end
  // Wait is low with the strobe for wait_len_i clocks, then released.
  assign card_wait_n_o = !((!strobe_rd_n_i || !strobe_wr_n_i) && cnt < wait_len_i);
endmodule

// ### testbench/tb_top.sv
// Testbench for the card cycle timer: registers, every timing case, wait, reset.
// Assumes the card model on the card pins and the bound checker.
`timescale 1ns/1ps
module tb_top;
  import card_timer_pkg::*;
  logic clock_i, nrst_i, reg_wr_i, reg_rd_i, req_i, card_wait_n;
  logic [ADDR_W-1:0] reg_addr_i;
  logic [DATA_W-1:0] reg_wdata_i, reg_rdata_o;
  cycle_req_t req_info_i;
  logic busy_o, done_o, addr_valid_o, card_io_o, strobe_rd_n_o, strobe_wr_n_o;
  logic [5:0] wait_len;
  int err_total, n_tests;

  card_cycle_timer card_cycle_timer_i (.clock_i, .nrst_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .req_i, .req_info_i, .busy_o, .done_o,
    .card_wait_n_i(card_wait_n), .addr_valid_o, .card_io_o, .strobe_rd_n_o, .strobe_wr_n_o);
  card_model card_model_i (.clock_i, .nrst_i, .strobe_rd_n_i(strobe_rd_n_o),
    .strobe_wr_n_i(strobe_wr_n_o), .wait_len_i(wait_len), .card_wait_n_o(card_wait_n));

  // ---------------------------------------------------------------
  // Tasks.
  // ---------------------------------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    $display("mismatches %0d of %0d checks", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Writes keep one idle cycle so the strobe is never reassigned in one step.
  task wr(input logic [3:0] a, input logic [7:0] d);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    @(negedge clock_i);
    check(reg_rdata_o & m, e);
    @(posedge clock_i);
  endtask
  function automatic int act(logic io, logic wide, logic [1:0] ws, logic z);
    if (!wide) return ((io ? ws[0] : ws != 2'b00) ? 23 : (z ? 7 : 19));
    if (io) return ws[0] ? 11 : 7;
    if (z && ws == 2'b00) return 5;
    return 9 + 4 * ws + (ws == 2'b11 ? 2 : 0);
  endfunction
  // Window w holds wait field w[1:0] and zero-wait w[2]; w[0] picks a write.
  task automatic run(input logic [2:0] w, input logic io, input logic wide);
    int ns = 0;
    int na = 0;
    int nh = 0;
    int k;
    req_i <= 1'b1;
    req_info_i <= '{w, io, wide, w[0]};
    @(posedge clock_i);
    req_i <= 1'b0;
    for (k = 0; k < 300; k++) begin
      @(negedge clock_i);
      if (!busy_o) break;
      if (!(w[0] ? strobe_wr_n_o : strobe_rd_n_o)) na++;
      else if (na == 0) ns++;
      else nh++;
    end
    if (k == 300) begin
      err_total++;
      wrap_up;
    end
    check(8'(ns), 8'(io ? 5 : (w[1] ? 6 : 4)));
    if (wait_len == 0) check(8'(na), 8'(act(io, wide, w[1:0], w[2])));
    else check(8'(na >= wait_len), 8'h01);
    check(8'(nh), 8'(io ? 3 : (w[1] ? 4 : 3)));
    check({6'h00, done_o, card_io_o}, {6'h00, 1'b1, io});
    @(posedge clock_i);
  endtask

  // ---------------------------------------------------------------
  // Main sequence.
  // ---------------------------------------------------------------
  initial begin
    nrst_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    req_i = 1'b0;
    reg_addr_i = '0;
    reg_wdata_i = '0;
    req_info_i = '0;
    wait_len = '0;
    err_total = 0;
    n_tests = 0;
    repeat (12) @(posedge clock_i);
    nrst_i <= 1'b1;
    rd(4'h3, 8'hff, WIN_RESET);
    rd(4'h8, 8'h0d, 8'h00);
    for (int i = 0; i < 8; i++) wr(4'(i), 8'h08 | 8'(i));
    wr(4'h9, 8'hff);
    rd(4'h9, 8'hff, 8'h00);
    for (int i = 0; i < 8; i++) rd(4'(i), 8'h1f, 8'h08 | 8'(i));
    // Every window against every width and cycle type.
    for (int i = 0; i < 32; i++) run(3'(i), i[3], i[4]);
    wait_len <= 6'd30;
    run(3'h0, 1'b0, 1'b1);
    wait_len <= '0;
    // Reset in mid-cycle must drop the strobe and the cycle at once.
    req_i <= 1'b1;
    req_info_i <= '{3'h7, 1'b0, 1'b0, 1'b1};
    @(posedge clock_i);
    req_i <= 1'b0;
    repeat (9) @(posedge clock_i);
    nrst_i <= 1'b0;
    @(negedge clock_i);
    check({4'h0, busy_o, addr_valid_o, strobe_rd_n_o, strobe_wr_n_o}, 8'h03);
    @(posedge clock_i);
    nrst_i <= 1'b1;
    rd(4'h7, 8'hff, WIN_RESET);
    run(3'h0, 1'b0, 1'b0);
    wrap_up;
  end
endmodule
